// ### core/wdrst_defines.svh
`ifndef WDRST_DEFINES_SVH
`define WDRST_DEFINES_SVH

// ==========================================
// Register offsets (byte addresses)
`define WDRST_OFF_STATUS 12'h000
`define WDRST_OFF_CONTROL 12'h004

// ==========================================
// Status field positions
`define WDRST_ST_POWER 0
`define WDRST_ST_PIN 1
`define WDRST_ST_BROWNOUT 2
`define WDRST_ST_WATCHDOG 3
`define WDRST_ST_SCAN 4
`define WDRST_STATUS_RESET 5'h01

// ==========================================
// Control field positions
`define WDRST_CT_SEL_LSB 0
`define WDRST_CT_SEL_MSB 2
`define WDRST_CT_ENABLE 3
`define WDRST_CT_CHANGE 4
`define WDRST_SEL_RESET 3'h0

// ==========================================
// Timing
`define WDRST_CHANGE_CYCLES 3'h4
`define WDRST_BASE_LOG2 5'h0E
`define WDRST_CNT_W 21

`endif

// ### core/wdrst_pkg.sv
package wdrst_pkg;

  typedef enum logic [1:0] {
    WDRST_APB_IDLE = 2'b01,
    WDRST_APB_RESP = 2'b10
  } wdrst_apb_state_type;

  typedef logic [2:0] wdrst_sel_type;

endpackage : wdrst_pkg

// ### core/wdrst_sync.sv
`timescale 1ns/1ps
// ==========================================
// Two-flop synchroniser for asynchronous levels
module wdrst_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // asynchronous levels
  output logic [WIDTH-1:0] sync_out // synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : wdrst_sync

// ### core/wdrst_top.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "wdrst_defines.svh"
module wdrst_top (
  input wire logic pclk, // system clock, 25 MHz
  input wire logic presetn, // power-on reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic wdt_osc, // watchdog oscillator, asynchronous
  input wire logic safety_level_fuse, // high selects higher safety level
  input wire logic pin_reset_in, // external pin reset active, async
  input wire logic brownout_reset_in, // brown-out reset active, async
  input wire logic scan_reset_in, // scan chain reset held, async
  input wire logic watchdog_restart, // restart instruction, one pclk
  output logic wdt_reset_pulse, // internal watchdog reset, one pclk
  output logic wdt_running // watchdog effectively enabled
);

  // ==========================================
  // Input synchronisers
  logic [4:0] sync_lv;
  logic osc_s;
  logic fuse_s;
  logic pin_s;
  logic bor_s;
  logic scan_s;

  wdrst_sync #(
    .WIDTH(5)
  ) i_wdrst_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({wdt_osc, safety_level_fuse, pin_reset_in, brownout_reset_in, scan_reset_in}),
    .sync_out(sync_lv)
  );

  assign osc_s = sync_lv[4];
  assign fuse_s = sync_lv[3];
  assign pin_s = sync_lv[2];
  assign bor_s = sync_lv[1];
  assign scan_s = sync_lv[0];

  // ==========================================
  // APB slave
  wdrst_pkg::wdrst_apb_state_type apb_q;
  wdrst_pkg::wdrst_apb_state_type apb_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic hit_status;
  logic hit_control;
  logic wr_status;
  logic wr_control;
  logic [4:0] status_q;
  logic [4:0] status_d;
  wdrst_pkg::wdrst_sel_type sel_q;
  wdrst_pkg::wdrst_sel_type sel_d;
  logic enable_q;
  logic enable_d;
  logic change_q;
  logic change_d;
  logic [2:0] change_cnt_q;
  logic [2:0] change_cnt_d;
  logic enable_eff;
  logic [7:0] control_rd;

  assign hit_status = (paddr == `WDRST_OFF_STATUS);
  assign hit_control = (paddr == `WDRST_OFF_CONTROL);
  // Writes land at the edge where pready is sampled high
  assign wr_status = pready_q && psel && penable && pwrite && hit_status;
  assign wr_control = pready_q && psel && penable && pwrite && hit_control;

  // Fuse forces enable at the higher level
  assign enable_eff = enable_q | fuse_s;
  assign control_rd = {3'h0, change_q, enable_eff, sel_q};

  always_comb
  begin
    apb_d = apb_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    case (apb_q)
      wdrst_pkg::WDRST_APB_IDLE:
      begin
        if (psel && penable)
        begin
          apb_d = wdrst_pkg::WDRST_APB_RESP;
          pready_d = 1'b1;
          pslverr_d = !(hit_status || hit_control);
          if (hit_status && !pwrite)
          begin
            prdata_d = {27'h0, status_q};
          end
          else if (hit_control && !pwrite)
          begin
            prdata_d = {24'h0, control_rd};
          end
          else
          begin
            prdata_d = 32'h0;
          end
        end
      end
      wdrst_pkg::WDRST_APB_RESP:
      begin
        apb_d = wdrst_pkg::WDRST_APB_IDLE;
      end
      default:
      begin
        apb_d = wdrst_pkg::WDRST_APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_q <= wdrst_pkg::WDRST_APB_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      apb_q <= apb_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================
  // Reset cause flags
  logic wdt_fire_q;
  logic wdt_fire_d;
  logic chip_reset;

  // Any non-power reset also reinitialises the watchdog
  assign chip_reset = pin_s || bor_s || scan_s || wdt_fire_q;

  always_comb
  begin
    status_d = status_q;
    // Clears first so a coincident cause wins
    if (wr_status)
    begin
      status_d = status_q & pwdata[4:0];
    end
    if (scan_s)
    begin
      status_d[`WDRST_ST_SCAN] = 1'b1;
    end
    if (wdt_fire_q)
    begin
      status_d[`WDRST_ST_WATCHDOG] = 1'b1;
    end
    if (bor_s)
    begin
      status_d[`WDRST_ST_BROWNOUT] = 1'b1;
    end
    if (pin_s)
    begin
      status_d[`WDRST_ST_PIN] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= `WDRST_STATUS_RESET;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // ==========================================
  // Watchdog control with timed change window
  always_comb
  begin
    enable_d = enable_q;
    sel_d = sel_q;
    change_d = change_q;
    change_cnt_d = change_cnt_q;
    if (change_q)
    begin
      if (change_cnt_q == 3'h1)
      begin
        change_d = 1'b0;
      end
      change_cnt_d = change_cnt_q - 3'h1;
    end
    if (wr_control)
    begin
      if (pwdata[`WDRST_CT_CHANGE] && pwdata[`WDRST_CT_ENABLE])
      begin
        // Opening write arms the window and also sets enable
        change_d = 1'b1;
        change_cnt_d = `WDRST_CHANGE_CYCLES;
        enable_d = 1'b1;
      end
      else
      begin
        if (pwdata[`WDRST_CT_ENABLE])
        begin
          enable_d = 1'b1;
        end
        else if (change_q)
        begin
          enable_d = 1'b0;
        end
        if (change_q)
        begin
          sel_d = pwdata[`WDRST_CT_SEL_MSB:`WDRST_CT_SEL_LSB];
        end
      end
    end
    if (chip_reset)
    begin
      enable_d = 1'b0;
      sel_d = `WDRST_SEL_RESET;
      change_d = 1'b0;
      change_cnt_d = 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_q <= 1'b0;
      sel_q <= `WDRST_SEL_RESET;
      change_q <= 1'b0;
      change_cnt_q <= 3'h0;
    end
    else
    begin
      enable_q <= enable_d;
      sel_q <= sel_d;
      change_q <= change_d;
      change_cnt_q <= change_cnt_d;
    end
  end

  // ==========================================
  // Watchdog counter on oscillator edges
  logic osc_prev_q;
  logic osc_prev_d;
  logic osc_tick;
  logic [`WDRST_CNT_W-1:0] cnt_q;
  logic [`WDRST_CNT_W-1:0] cnt_d;
  logic [`WDRST_CNT_W-1:0] limit_m1;
  logic running_q;
  logic running_d;

  assign osc_tick = osc_s && !osc_prev_q;
  // 16K shifted left by the select code
  assign limit_m1 = `WDRST_CNT_W'((22'h1 << (`WDRST_BASE_LOG2 + {2'h0, sel_q})) - 22'h1);

  always_comb
  begin
    cnt_d = cnt_q;
    osc_prev_d = osc_s;
    wdt_fire_d = 1'b0;
    running_d = enable_eff;
    if (!enable_eff || watchdog_restart || chip_reset)
    begin
      cnt_d = '0;
    end
    else if (osc_tick)
    begin
      // Compare with >= so a shorter select never skips the end
      if (cnt_q >= limit_m1)
      begin
        cnt_d = '0;
        wdt_fire_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + `WDRST_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_prev_q <= 1'b0;
      cnt_q <= '0;
      wdt_fire_q <= 1'b0;
      running_q <= 1'b0;
    end
    else
    begin
      osc_prev_q <= osc_prev_d;
      cnt_q <= cnt_d;
      wdt_fire_q <= wdt_fire_d;
      running_q <= running_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wdt_reset_pulse = wdt_fire_q;
  assign wdt_running = running_q;

endmodule : wdrst_top

// ### tb/wdrst_checker.sv
`timescale 1ns/1ps
// ======
// Port checker
module wdrst_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic safety_level_fuse, // fuse
  input wire logic pin_reset_in, // pin reset
  input wire logic wdt_reset_pulse, // timeout
  input wire logic wdt_running // enabled
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_pulse_single: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
    else $error("reset pulse too long");
  a_ready_access: assert property ($rose(penable) && psel |=> pready)
    else $error("no ready");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready too long");
  a_unmapped_err: assert property (pready |-> pslverr == !(paddr == 12'h000 || paddr == 12'h004))
    else $error("bad error flag");
  a_reserved_zero: assert property (pready && !pwrite |-> prdata[31:5] == 27'h0)
    else $error("reserved bits set");
  a_fuse_reads_one: assert property (pready && !pwrite && paddr == 12'h004
    && safety_level_fuse && $past(safety_level_fuse, 4) |-> prdata[3])
    else $error("enable reads zero");
  a_fuse_running: assert property (safety_level_fuse && $past(safety_level_fuse, 5)
    && $past(presetn, 5) |-> wdt_running)
    else $error("watchdog off at high level");
  a_pin_disables: assert property ((pin_reset_in && !safety_level_fuse)[*5] |-> !wdt_running)
    else $error("running through chip reset");
  a_pulse_needs_run: assert property ($rose(wdt_reset_pulse) |-> $past(wdt_running))
    else $error("pulse while stopped");
endmodule : wdrst_checker

bind wdrst_top wdrst_checker i_wdrst_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .safety_level_fuse(safety_level_fuse), .pin_reset_in(pin_reset_in),
  .wdt_reset_pulse(wdt_reset_pulse), .wdt_running(wdt_running));

// ### tb/wdrst_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module wdrst_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, wdt_reset_pulse, wdt_running, err;
  logic fuse = 1'b0, restart = 1'b0, osc_on = 1'b0;
  logic [2:0] rst_v = 3'h0;
  logic [1:0] osc_div = 2'h0;
  logic [7:0] rd;
  logic [7:0] exp_st [3] = '{8'h02, 8'h04, 8'h10};
  int n_fail = 0, checked = 0, n;

  always #20 pclk = ~pclk;
  // Oscillator at a quarter of pclk, so the sync flops never miss an edge
  always @(posedge pclk) if (osc_on) osc_div <= osc_div + 2'h1;

  wdrst_top i_wdrst_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdt_osc(osc_div[1]), .safety_level_fuse(fuse),
    .pin_reset_in(rst_v[0]), .brownout_reset_in(rst_v[1]), .scan_reset_in(rst_v[2]),
    .watchdog_restart(restart), .wdt_reset_pulse(wdt_reset_pulse),
    .wdt_running(wdt_running));

  task report_and_stop;
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // ======
  // Bus access; k keeps psel up for a back-to-back transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic k);
    int t;
    t = 0;
    // Psel already up after a back-to-back transfer; never assign it twice
    if (psel !== 1'b1)
      psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk) penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1)
    begin
      n_fail++;
      report_and_stop();
    end
    rd = prdata[7:0];
    err = pslverr;
    penable <= 1'b0;
    if (!k)
    begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h000, 8'h00, 1);
    `CHK("status", 8'h01, rd)
    apb(0, 12'h004, 8'h00, 1);
    `CHK("control", 8'h00, rd)
    `CHK("running", 1'b0, wdt_running)
    apb(1, 12'h000, 8'h00, 1);
    apb(0, 12'h000, 8'h00, 1);
    `CHK("status", 8'h00, rd)
    apb(1, 12'h004, 8'hEF, 1);
    apb(0, 12'h004, 8'h00, 1);
    `CHK("control", 8'h08, rd)
    apb(1, 12'h004, 8'h00, 1);
    apb(0, 12'h004, 8'h00, 1);
    `CHK("control", 8'h08, rd)
    apb(1, 12'h004, 8'h18, 1);
    apb(1, 12'h004, 8'h05, 1);
    apb(0, 12'h004, 8'h00, 0);
    `CHK("control", 8'h05, rd)
    `CHK("running", 1'b0, wdt_running)
    // Window left to lapse before the disable attempt
    apb(1, 12'h004, 8'h18, 0);
    repeat (5) @(posedge pclk);
    apb(1, 12'h004, 8'h00, 1);
    apb(0, 12'h004, 8'h00, 0);
    `CHK("control", 8'h0D, rd)
    `CHK("running", 1'b1, wdt_running)
    apb(0, 12'h008, 8'h00, 0);
    `CHK("slverr", 1'b1, err)
    for (int i = 0; i < 3; i++)
    begin
      apb(1, 12'h000, 8'h00, 0);
      rst_v <= 3'h1 << i;
      repeat (6) @(posedge pclk);
      rst_v <= 3'h0;
      repeat (4) @(posedge pclk);
      apb(0, 12'h000, 8'h00, 0);
      `CHK("cause", exp_st[i], rd)
    end
    apb(1, 12'h000, 8'h00, 1);
    apb(1, 12'h004, 8'h08, 0);
    osc_on <= 1'b1;
    repeat (2000) @(posedge pclk);
    // Restart late, so a count that survived it would fire early
    restart <= 1'b1;
    @(posedge pclk) restart <= 1'b0;
    n = 0;
    while (wdt_reset_pulse !== 1'b1 && n < 70000)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK("timeout", 1'b1, n > 65400 && n < 65700)
    if (n >= 70000)
      report_and_stop();
    osc_on <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(0, 12'h000, 8'h00, 1);
    `CHK("status", 8'h08, rd)
    apb(0, 12'h004, 8'h00, 0);
    `CHK("control", 8'h00, rd)
    fuse <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(0, 12'h004, 8'h00, 1);
    `CHK("control", 8'h08, rd)
    apb(1, 12'h004, 8'h18, 1);
    apb(1, 12'h004, 8'h00, 0);
    `CHK("running", 1'b1, wdt_running)
    apb(0, 12'h004, 8'h00, 0);
    `CHK("control", 8'h08, rd)
    report_and_stop();
  end
endmodule : wdrst_tb_top
